// *** design/dcf_pkg.sv ***
// Shared constants and pointer helpers for the 64x18 dual-clock FIFO
package dcf_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int DATA_W = 18;
	localparam int DEPTH = 64;
	localparam int ADDR_W = 6;
	localparam int PTR_W = ADDR_W + 1;
	localparam int OFFSET_W = 5;
	// ------------------------------------------------------------
	// Flag thresholds and reset values
	// ------------------------------------------------------------
	localparam logic [PTR_W-1:0] FULL_LEVEL = 7'h40;
	localparam logic [PTR_W-1:0] HALF_LEVEL = 7'h20;
	localparam logic [OFFSET_W-1:0] DEFAULT_OFFSET = 5'h08;
	localparam logic [1:0] READY_STAGE = 2'h1;
	// ------------------------------------------------------------
	// Host clock divider: mclk / 4, high on phases 2 and 3
	// ------------------------------------------------------------
	localparam logic [1:0] PHASE_SETUP = 2'h0;
	localparam logic [1:0] PHASE_SENSE = 2'h3;

	// Binary to Gray for pointers crossing clock domains
	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	// Gray back to binary after synchronisation
	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b = '0;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction
endpackage

// *** design/dcf_if.sv ***
// Pin-level link between the FIFO and the logic that writes and reads it
`timescale 1ns/1ps
interface dcf_if;
	logic write_clock;
	logic write_qual_high;
	logic write_qual_low_n;
	logic offset_program_n;
	logic [dcf_pkg::DATA_W-1:0] write_data;
	logic input_ready;
	logic half_full_flag;
	logic almost_flag;
	logic read_clock;
	logic read_enable_n;
	logic output_enable_a_n;
	logic output_enable_b_n;
	logic [dcf_pkg::DATA_W-1:0] read_data;
	logic read_data_oe_n;
	logic output_ready;

	// FIFO side
	modport fifo_end (
		input write_clock, write_qual_high, write_qual_low_n, offset_program_n, write_data,
		input read_clock, read_enable_n, output_enable_a_n, output_enable_b_n,
		output input_ready, half_full_flag, almost_flag, read_data, read_data_oe_n,
		output output_ready
	);

	// Writing and reading logic side
	modport host_end (
		output write_clock, write_qual_high, write_qual_low_n, offset_program_n, write_data,
		output read_clock, read_enable_n, output_enable_a_n, output_enable_b_n,
		input input_ready, half_full_flag, almost_flag, read_data, read_data_oe_n,
		input output_ready
	);
endinterface

// *** design/dcf_skid.sv ***
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module dcf_skid #(
	parameter int W = dcf_pkg::DATA_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] d0_r;
	logic [W-1:0] d1_r;
	logic [1:0] n_r;
	logic [1:0] n_nxt;
	logic in_ready_r;
	logic out_valid_r;

	// Handshakes and occupancy
	wire push = in_valid & in_ready_r;
	wire pop = out_valid_r & out_ready;
	wire load_head_in = push & ((n_r == 2'h0) | ((n_r == 2'h1) & pop));
	wire load_head_tail = pop & (n_r == 2'h2);
	wire load_tail = push & (n_r == 2'h1) & ~pop;
	assign n_nxt = 2'(n_r + {1'b0, push} - {1'b0, pop});

	// Head register drives the output so downstream sees a flop
	always_ff @(posedge mclk)
	begin
		if (load_head_in)
			d0_r <= in_data;
		else if (load_head_tail)
			d0_r <= d1_r;
		if (load_tail)
			d1_r <= in_data;
	end

	// Flags precomputed so both ready and valid are flops
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			n_r <= 2'h0;
			in_ready_r <= 1'b0;
			out_valid_r <= 1'b0;
		end
		else
		begin
			n_r <= n_nxt;
			in_ready_r <= (n_nxt != 2'h2);
			out_valid_r <= (n_nxt != 2'h0);
		end
	end

	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data = d0_r;
endmodule

// *** design/dcf_host.sv ***
// Writing and reading logic that drives the FIFO pins from a user stream
`timescale 1ns/1ps
module dcf_host #(
	parameter int DW = dcf_pkg::DATA_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	dcf_if.host_end link,
	input wire logic wr_valid,
	input wire logic [DW-1:0] wr_data,
	output logic wr_ready,
	input wire logic prog_valid,
	input wire logic [dcf_pkg::OFFSET_W-1:0] prog_value,
	output logic prog_ready,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [DW-1:0] rd_data,
	input wire logic out_disable
);
	logic [1:0] cnt_r;
	logic wr_ready_r;
	logic prog_ready_r;
	logic qual_high_r;
	logic qual_low_n_r;
	logic prog_n_r;
	logic [DW-1:0] data_r;
	logic read_en_n_r;
	logic oe_n_r;
	logic buf_ready;

	// ------------------------------------------------------------
	// Phase decode; outputs move only while both clocks are low
	// ------------------------------------------------------------
	wire ph_setup = (cnt_r == dcf_pkg::PHASE_SETUP);
	wire ph_sense = (cnt_r == dcf_pkg::PHASE_SENSE);
	wire prog_take = ph_setup & prog_valid & prog_ready_r;
	wire wr_take = ph_setup & wr_valid & wr_ready_r & ~prog_take;
	// Word shown now is the one the next read edge consumes
	wire rd_take = ph_setup & link.output_ready & ~link.read_data_oe_n & ~oe_n_r
		& buf_ready & ~out_disable; // [R02]

	// Divider makes both link clocks; they run free and coincide [R16]
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			cnt_r <= 2'h0;
		else
			cnt_r <= 2'(cnt_r + 2'h1);
	end

	// Ready flags sampled after the FIFO has acted on the rising edge
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			wr_ready_r <= 1'b0;
			prog_ready_r <= 1'b0;
		end
		else
		begin
			wr_ready_r <= ph_sense & link.input_ready & ~prog_valid; // [R01]
			prog_ready_r <= ph_sense & link.input_ready; // [R13]
		end
	end

	// Pin drive, updated once per link clock period; strobe held high in reset
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			qual_high_r <= 1'b0;
			qual_low_n_r <= 1'b1;
			prog_n_r <= 1'b1; // [R14]
			data_r <= '0;
			read_en_n_r <= 1'b1;
			oe_n_r <= 1'b1;
		end
		else if (ph_setup)
		begin
			qual_high_r <= wr_take; // [R01]
			qual_low_n_r <= ~wr_take;
			prog_n_r <= ~prog_take; // [R18]
			data_r <= prog_take ? DW'(prog_value) : wr_data; // [R13]
			read_en_n_r <= ~rd_take; // [R02]
			oe_n_r <= out_disable;
		end
	end

	// Popped words land here so a stalled consumer drops nothing
	dcf_skid #(.W(DW)) u_skid (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(rd_take),
		.in_ready(buf_ready),
		.in_data(link.read_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	assign link.write_clock = cnt_r[1];
	assign link.read_clock = cnt_r[1];
	assign link.write_qual_high = qual_high_r;
	assign link.write_qual_low_n = qual_low_n_r;
	assign link.offset_program_n = prog_n_r;
	assign link.write_data = data_r;
	assign link.read_enable_n = read_en_n_r;
	assign link.output_enable_a_n = oe_n_r;
	assign link.output_enable_b_n = oe_n_r;
	assign wr_ready = wr_ready_r;
	assign prog_ready = prog_ready_r;
endmodule

// *** design/dcf_device.sv ***
// The 64x18 FIFO itself, sampling both link clocks on mclk
//
// Contract
// R01: Store word when qualifiers right and input ready
// R02: Pop only with all enables low, output ready
// R03: Either output enable high blocks reads, floats outputs
// R04: Input ready low when full; writes then ignored
// R05: Ready flags change only on their clock
// R06: Input ready rises second write edge after reset
// R07: Output ready low when empty; high means data
// R08: First word appears third read edge after write
// R09: Output holds last popped word while not ready
// R10: Half-full high at 32 words or more
// R11: Almost flag within empty or full offset
// R12: Unprogrammed offsets both default to eight
// R13: Program strobe after reset captures offset bits
// R14: Reset held; clears flags, almost flag high
// R15: Eighteen-bit data ports, sixty-four words deep
// R16: Both clocks run continuously, any phase relation
// R17: First word reaches output regardless of enables
// R18: First strobe loads both, second only full
// R19: Programming suppresses storage writes
// R20: Gray pointers through two-stage synchronisers
`timescale 1ns/1ps
module dcf_device #(
	parameter int DW = dcf_pkg::DATA_W,
	parameter int AW = dcf_pkg::ADDR_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	dcf_if.fifo_end link,
	output logic [AW:0] fill_level
);
	localparam int PW = AW + 1;
	localparam int DEPTH = 1 << AW;

	// ------------------------------------------------------------
	// Storage and clock edge detection
	// ------------------------------------------------------------
	logic [DW-1:0] mem_r [DEPTH]; // [R15]
	logic wclk_q_r;
	logic rclk_q_r;

	// ------------------------------------------------------------
	// Write side state
	// ------------------------------------------------------------
	logic [PW-1:0] wbin_r;
	logic [PW-1:0] wgray_r;
	logic [PW-1:0] rg_s1_r;
	logic [PW-1:0] rg_s2_r;
	logic [1:0] stage_r;
	logic in_rdy_r;
	logic half_r;
	logic almost_r;
	logic [dcf_pkg::OFFSET_W-1:0] xoff_r;
	logic [dcf_pkg::OFFSET_W-1:0] yoff_r;
	logic prog_prev_r;
	logic written_r;
	logic [PW-1:0] level_r;

	// ------------------------------------------------------------
	// Read side state
	// ------------------------------------------------------------
	logic [PW-1:0] rbin_r;
	logic [PW-1:0] rgray_r;
	logic [PW-1:0] wg_s1_r;
	logic [PW-1:0] wg_s2_r;
	logic or_r;
	logic [DW-1:0] q_r;
	logic qoe_n_r;

	// Inputs are synchronous to mclk, so one flop is enough for edges
	wire wr_edge = link.write_clock & ~wclk_q_r;
	wire rd_edge = link.read_clock & ~rclk_q_r;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			wclk_q_r <= 1'b0;
			rclk_q_r <= 1'b0;
		end
		else
		begin
			wclk_q_r <= link.write_clock;
			rclk_q_r <= link.read_clock;
		end
	end

	// ------------------------------------------------------------
	// Write side decode
	// ------------------------------------------------------------
	// Read pointer as seen after synchronising; may lag, never leads
	wire [PW-1:0] rbin_w = dcf_pkg::gray2bin(rg_s2_r); // [R20]
	wire prog_low = ~link.offset_program_n;
	// Offsets only before the first stored word, and only when ready
	wire prog_take = wr_edge & prog_low & ~written_r & in_rdy_r; // [R13]
	// Strobe low disables storage whatever the qualifiers say
	wire do_write = wr_edge & link.write_qual_high & ~link.write_qual_low_n
		& in_rdy_r & ~prog_low; // [R01] [R04] [R19]
	wire [PW-1:0] wbin_nxt = PW'(wbin_r + {{(PW-1){1'b0}}, do_write});
	wire [PW-1:0] level_nxt = PW'(wbin_nxt - rbin_w);
	wire full_nxt = (level_nxt == dcf_pkg::FULL_LEVEL);
	wire half_nxt = (level_nxt >= dcf_pkg::HALF_LEVEL); // [R10]
	wire [PW-1:0] af_thresh = PW'(dcf_pkg::FULL_LEVEL - PW'(yoff_r));
	wire almost_nxt = (level_nxt <= PW'(xoff_r)) | (level_nxt >= af_thresh); // [R11]

	// Storage array has no reset; contents are don't-care until written
	always_ff @(posedge mclk)
	begin
		if (do_write)
			mem_r[wbin_r[AW-1:0]] <= link.write_data; // [R01]
	end

	// Pointer, synchroniser and flags, all stepping on write edges only
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			wbin_r <= '0;
			wgray_r <= '0;
			rg_s1_r <= '0;
			rg_s2_r <= '0;
			stage_r <= 2'h0;
			in_rdy_r <= 1'b0; // [R14]
			half_r <= 1'b0; // [R14]
			almost_r <= 1'b1; // [R14]
			level_r <= '0;
			written_r <= 1'b0;
		end
		else if (wr_edge) // [R05]
		begin
			wbin_r <= wbin_nxt;
			wgray_r <= dcf_pkg::bin2gray(wbin_nxt); // [R20]
			rg_s1_r <= rgray_r;
			rg_s2_r <= rg_s1_r; // [R20]
			if (stage_r != dcf_pkg::READY_STAGE)
				stage_r <= 2'(stage_r + 2'h1);
			// First edge only advances the stage; second may raise ready
			in_rdy_r <= (stage_r == dcf_pkg::READY_STAGE) & ~full_nxt; // [R04] [R06]
			half_r <= half_nxt; // [R10]
			almost_r <= almost_nxt; // [R11]
			level_r <= level_nxt;
			written_r <= written_r | do_write;
		end
	end

	// Offset loading: first low edge sets both, a consecutive one only Y
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			xoff_r <= dcf_pkg::DEFAULT_OFFSET; // [R12]
			yoff_r <= dcf_pkg::DEFAULT_OFFSET; // [R12]
			prog_prev_r <= 1'b0;
		end
		else if (wr_edge)
		begin
			prog_prev_r <= prog_take;
			if (prog_take && !prog_prev_r)
			begin
				xoff_r <= link.write_data[dcf_pkg::OFFSET_W-1:0]; // [R13] [R18]
				yoff_r <= link.write_data[dcf_pkg::OFFSET_W-1:0];
			end
			else if (prog_take)
				yoff_r <= link.write_data[dcf_pkg::OFFSET_W-1:0]; // [R18]
		end
	end

	// ------------------------------------------------------------
	// Read side decode
	// ------------------------------------------------------------
	wire [PW-1:0] wbin_r_sync = dcf_pkg::gray2bin(wg_s2_r); // [R20]
	wire avail = (wbin_r_sync != rbin_r);
	wire oe_block = link.output_enable_a_n | link.output_enable_b_n; // [R03]
	wire pop = rd_edge & or_r & ~link.read_enable_n & ~oe_block; // [R02] [R03]
	// An empty output register fills with no enable involved
	wire load = rd_edge & avail & (~or_r | pop); // [R17]

	// Output register, pointer and ready flag step on read edges only
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rbin_r <= '0;
			rgray_r <= '0;
			wg_s1_r <= '0;
			wg_s2_r <= '0;
			or_r <= 1'b0; // [R14]
			q_r <= '0;
		end
		else if (rd_edge) // [R05]
		begin
			wg_s1_r <= wgray_r;
			wg_s2_r <= wg_s1_r; // [R08] [R20]
			if (load)
			begin
				q_r <= mem_r[rbin_r[AW-1:0]]; // [R07] [R08]
				rbin_r <= PW'(rbin_r + 1'b1);
				rgray_r <= dcf_pkg::bin2gray(PW'(rbin_r + 1'b1));
				or_r <= 1'b1; // [R08]
			end
			else if (pop)
				or_r <= 1'b0; // [R07] [R09]
		end
	end

	// Float indication lags the enables by one mclk so it stays a flop
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			qoe_n_r <= 1'b1;
		else
			qoe_n_r <= oe_block; // [R03]
	end

	// Pin drive; read data keeps the last popped word while not ready
	assign link.input_ready = in_rdy_r;
	assign link.half_full_flag = half_r;
	assign link.almost_flag = almost_r;
	assign link.output_ready = or_r;
	assign link.read_data = q_r; // [R09]
	assign link.read_data_oe_n = qoe_n_r;
	assign fill_level = level_r;
endmodule

// *** testbench/dcf_monitor.sv ***
// Concurrent checks on the link between host and FIFO
`timescale 1ns/1ps
module dcf_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic write_clock,
	input wire logic write_qual_high,
	input wire logic write_qual_low_n,
	input wire logic offset_program_n,
	input wire logic input_ready,
	input wire logic read_clock,
	input wire logic read_enable_n,
	input wire logic output_enable_a_n,
	input wire logic output_enable_b_n,
	input wire logic [dcf_pkg::DATA_W-1:0] read_data,
	input wire logic read_data_oe_n,
	input wire logic output_ready
);
	// ----------------------------------------
	// Link edges and word tally
	// ----------------------------------------
	logic wclk_r, rclk_r;
	logic [1:0] wseen_r;
	logic [7:0] held_r;
	wire logic wrise = write_clock & ~wclk_r;
	wire logic rrise = read_clock & ~rclk_r;
	wire logic oe_off = output_enable_a_n | output_enable_b_n;
	wire logic take = wrise & write_qual_high & ~write_qual_low_n & offset_program_n & input_ready;
	wire logic pop = rrise & ~read_enable_n & ~oe_off & output_ready;

	// Tally includes the output register word, so full is 65
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			wclk_r <= 1'h0;
			rclk_r <= 1'h0;
			wseen_r <= 2'h0;
			held_r <= 8'h00;
		end
		else
		begin
			wclk_r <= write_clock;
			rclk_r <= read_clock;
			held_r <= held_r + {7'h00, take} - {7'h00, pop};
			if (wrise && wseen_r != 2'h3)
				wseen_r <= wseen_r + 2'h1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence empty_take_s;
		take && held_r == 8'h00;
	endsequence
	// Too early and too late both fail here: twelve quiet samples, ready on the next
	sequence or_third_s;
		!output_ready [*8] ##1 !output_ready [*4] ##1 output_ready;
	endsequence

	in_rdy_moves_a: assert property ($changed(input_ready) |-> $past(wrise))
		else $error("input ready moved off a write edge");
	or_edge_only_a: assert property ($changed(output_ready) |-> $past(rrise))
		else $error("output ready moved off a read edge");
	float_lag_a: assert property (read_data_oe_n == $past(oe_off))
		else $error("data float does not follow the enables");
	no_pop_a: assert property ((oe_off || read_enable_n) && output_ready
		|=> $stable(read_data) && output_ready) else $error("word popped while blocked");
	hold_empty_a: assert property (!output_ready ##1 !output_ready |-> $stable(read_data))
		else $error("data moved while not ready");
	in_rdy_start_a: assert property (wrise && wseen_r == 2'h1 |=> input_ready)
		else $error("input ready late after reset");
	in_rdy_early_a: assert property (wseen_r < 2'h2 |-> !input_ready)
		else $error("input ready early after reset");
	empty_or_a: assert property (held_r == 8'h00 |-> !output_ready)
		else $error("output ready while empty");
	first_word_a: assert property (empty_take_s |=> or_third_s)
		else $error("first word not on third read edge");
	full_blocks_a: assert property (held_r == 8'h41 |-> !input_ready)
		else $error("input ready high while full");
endmodule

// *** testbench/tb_dual_clock_fifo_64x18.sv ***
// Self-checking bench: host and FIFO joined across the link
`timescale 1ns/1ps
module tb_dual_clock_fifo_64x18;
	// ----------------------------------------
	// Stimulus, scoreboard and instances
	// ----------------------------------------
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	logic wr_valid = 1'h0;
	logic [dcf_pkg::DATA_W-1:0] wr_data = 18'h00000;
	logic prog_valid = 1'h0;
	logic [dcf_pkg::OFFSET_W-1:0] prog_value = 5'h00;
	logic rd_ready = 1'h0;
	logic out_disable = 1'h1;
	logic wr_ready, prog_ready, rd_valid;
	logic [dcf_pkg::DATA_W-1:0] rd_data;
	logic [dcf_pkg::DATA_W-1:0] exp_q[$];
	logic [4:0] off;
	logic [4:0] offx;
	logic [dcf_pkg::ADDR_W:0] fill_level;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 87;
	int n;
	bit ok;

	// 10 MHz
	always #50 mclk = ~mclk;

	dcf_if i_dcf_if();
	dcf_host i_dcf_host (.mclk(mclk), .reset_n(reset_n), .link(i_dcf_if),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.prog_valid(prog_valid), .prog_value(prog_value), .prog_ready(prog_ready),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.out_disable(out_disable));
	dcf_device i_dcf_device (.mclk(mclk), .reset_n(reset_n), .link(i_dcf_if),
		.fill_level(fill_level));
	dcf_monitor i_dcf_monitor (.mclk(mclk), .reset_n(reset_n),
		.write_clock(i_dcf_if.write_clock), .write_qual_high(i_dcf_if.write_qual_high),
		.write_qual_low_n(i_dcf_if.write_qual_low_n),
		.offset_program_n(i_dcf_if.offset_program_n), .input_ready(i_dcf_if.input_ready),
		.read_clock(i_dcf_if.read_clock), .read_enable_n(i_dcf_if.read_enable_n),
		.output_enable_a_n(i_dcf_if.output_enable_a_n),
		.output_enable_b_n(i_dcf_if.output_enable_b_n), .read_data(i_dcf_if.read_data),
		.read_data_oe_n(i_dcf_if.read_data_oe_n), .output_ready(i_dcf_if.output_ready));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offer one word at a falling edge; note it once the host takes it
	task automatic send(input logic [17:0] w, output bit took);
		int k;
		took = 1'b0;
		wr_valid = 1'h1;
		wr_data = w;
		for (k = 0; k < 40 && !took; k++)
		begin
			if (wr_ready === 1'h1)
			begin
				took = 1'b1;
				exp_q.push_back(w);
			end
			@(negedge mclk);
		end
		wr_valid = 1'h0;
	endtask

	// Watcher: pre-edge values are the ones the handshake uses
	always @(posedge mclk)
		if (rd_valid === 1'h1 && rd_ready === 1'h1)
			chk(rd_data, exp_q.size() != 0 ? exp_q.pop_front() : ~rd_data);

	// Hang guard, well above two full fill and drain passes
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			mismatches++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence: default offsets, then programmed ones
	// ----------------------------------------
	initial
	begin
		for (int p = 0; p < 2; p++)
		begin
			reset_n = 1'h0;
			out_disable = 1'h1;
			rd_ready = 1'h0;
			off = 5'h08;
			offx = 5'h08;
			// Long reset; the link clocks restart from phase 0 when it ends
			repeat (16) @(negedge mclk);
			chk(18'({i_dcf_if.input_ready, i_dcf_if.output_ready, i_dcf_if.half_full_flag,
				i_dcf_if.almost_flag}), 18'h00001);
			reset_n = 1'h1;
			// Two strobe edges in a row: both offsets, then the full one alone
			if (p == 1)
			begin
				offx = 5'($random(seed));
				off = 5'($random(seed));
				prog_valid = 1'h1;
				for (int k = 0; k < 2; k++)
				begin
					prog_value = (k == 0) ? offx : off;
					n = 0;
					while (prog_ready !== 1'h1 && n < 40)
					begin
						@(negedge mclk);
						n++;
					end
					chk(18'(n < 40), 18'h00001);
					@(negedge mclk);
				end
				prog_valid = 1'h0;
			end
			// Fill with reads shut off; the first word still reaches the output
			n = 0;
			ok = 1'b1;
			while (ok)
			begin
				send(18'($random(seed)), ok);
				if (ok)
					n++;
				repeat (4) @(negedge mclk);
				if (ok && n >= 8)
				begin
					chk(18'(i_dcf_if.half_full_flag), 18'(n > 32));
					chk(18'(i_dcf_if.almost_flag), 18'(n - 1 <= offx || n >= 65 - off));
				end
			end
			chk(18'(n), 18'h00041);
			chk(18'(fill_level), 18'h00040);
			chk(18'({i_dcf_if.input_ready, i_dcf_if.half_full_flag, i_dcf_if.almost_flag}),
				18'h00003);
			// Drain with the consumer stalling and outputs blocked at random
			out_disable = 1'h0;
			n = 0;
			while (exp_q.size() != 0 && n < 3000)
			begin
				@(negedge mclk);
				rd_ready = 1'($random(seed));
				out_disable = 1'(($random(seed) & 15) == 0);
				n++;
			end
			repeat (40) @(negedge mclk);
			chk(18'(exp_q.size()), 18'h00000);
			chk(18'(fill_level), 18'h00000);
			chk(18'({i_dcf_if.output_ready, i_dcf_if.half_full_flag, i_dcf_if.almost_flag,
				rd_valid}), 18'h00002);
		end
		print_verdict();
	end
endmodule
